//--- logic/arl_host_driver.sv
// module: host driver end, axi4-lite registers to cable sequencer
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module arl_host_driver import arl_pkg::*; #(
  parameter int HOLD_CYC = 6
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  arl_bus_if.host bus
);
  // the hold counter is 8 bits and the board needs six cycles per strobe
  if (HOLD_CYC < 6 || HOLD_CYC > 255) begin : g_holdChk
    $error("HOLD_CYC out of range");
  end

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [ARL_ADDR_W-1:0] board_q;
  logic [7:0] wdata_q, rdata_q;
  logic rdOp_q, clrOp_q, rmwOp_q, busy_q;
  logic [7:0] cnt_q;
  arl_state_t state_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awHave_q, wHave_q;
  logic [7:0] datBus_q;
  logic pw_q, dw_q, dr_q, clr_q;
  logic [7:0] bdMeta_q, bdSync_q;

  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire wrCtrl = doWrite && awAddr_q == ARL_OFS_CTRL && wStrb_q[0];
  wire wrBoard = doWrite && awAddr_q == ARL_OFS_BOARD && wStrb_q[0];
  wire wrData = doWrite && awAddr_q == ARL_OFS_WDATA && wStrb_q[0];
  wire wrOk = awAddr_q == ARL_OFS_CTRL || awAddr_q == ARL_OFS_BOARD ||
    awAddr_q == ARL_OFS_WDATA || awAddr_q == ARL_OFS_STAT ||
    awAddr_q == ARL_OFS_RDATA;
  wire start = wrCtrl && !busy_q && wData_q[ARL_CTRL_GO];
  wire holdDone = cnt_q == 8'(HOLD_CYC - 1);

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ARL_RESP_OK;
    end else if (clkEn) begin
      s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? ARL_RESP_OK : ARL_RESP_SLVERR;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------
  wire [31:0] rdMux =
    (s_axi_araddr == ARL_OFS_CTRL) ?
      {28'h0, rmwOp_q, clrOp_q, rdOp_q, busy_q} :
    (s_axi_araddr == ARL_OFS_BOARD) ? {26'h0, board_q} :
    (s_axi_araddr == ARL_OFS_WDATA) ? {24'h0, wdata_q} :
    (s_axi_araddr == ARL_OFS_STAT) ? {31'h0, busy_q} :
    (s_axi_araddr == ARL_OFS_RDATA) ? {24'h0, rdata_q} : 32'h0;
  wire rdOk = s_axi_araddr <= ARL_OFS_RDATA && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ARL_RESP_OK;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? ARL_RESP_OK : ARL_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // cable sequencer
  // ------------------------------------------------------------
  // the pointer, clear and write phases hold their strobe for HOLD_CYC cycles and the read strobe one cycle more, long enough for
  // the board's two-stage sampling plus one cycle to act on it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      board_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rdOp_q <= 1'b0;
      clrOp_q <= 1'b0;
      rmwOp_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
      state_q <= ARL_IDLE;
      datBus_q <= '0;
      pw_q <= 1'b0;
      dw_q <= 1'b0;
      dr_q <= 1'b0;
      clr_q <= 1'b0;
      bdMeta_q <= '0;
      bdSync_q <= '0;
    end else if (clkEn) begin
      bdMeta_q <= bus.boardData;
      bdSync_q <= bdMeta_q;
      if (wrBoard && !busy_q) board_q <= wData_q[ARL_ADDR_W-1:0];
      if (wrData && !busy_q) wdata_q <= wData_q[7:0];
      // capture starts the write phase, so it must restart the count too
      cnt_q <= (state_q == ARL_IDLE || state_q == ARL_CAP || holdDone) ?
        8'h00 : cnt_q + 8'h01;
      case (state_q)
        ARL_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            rdOp_q <= wData_q[ARL_CTRL_RD];
            clrOp_q <= wData_q[ARL_CTRL_CLR];
            rmwOp_q <= wData_q[ARL_CTRL_RMW];
            clr_q <= wData_q[ARL_CTRL_CLR];
            pw_q <= !wData_q[ARL_CTRL_CLR];
            datBus_q <= {2'h0, board_q};
            state_q <= ARL_PTR;
          end
        end
        ARL_PTR: begin
          if (holdDone) begin
            pw_q <= 1'b0;
            clr_q <= 1'b0;
            if (clrOp_q) begin
              busy_q <= 1'b0;
              state_q <= ARL_IDLE;
            end else if (rdOp_q || rmwOp_q) begin
              dr_q <= 1'b1;
              state_q <= ARL_READ;
            end else begin
              dw_q <= 1'b1;
              datBus_q <= wdata_q;
              state_q <= ARL_WRITE;
            end
          end
        end
        ARL_READ: begin
          if (holdDone) begin
            state_q <= ARL_CAP;
          end
        end
        ARL_CAP: begin
          dr_q <= 1'b0;
          rdata_q <= bdSync_q;
          if (rmwOp_q) begin
            dw_q <= 1'b1;
            datBus_q <= bdSync_q | wdata_q;
            state_q <= ARL_WRITE;
          end else begin
            busy_q <= 1'b0;
            state_q <= ARL_IDLE;
          end
        end
        ARL_WRITE: begin
          if (holdDone) begin
            dw_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= ARL_IDLE;
          end
        end
        default: state_q <= ARL_IDLE;
      endcase
    end
  end

  assign bus.ptrWrite = pw_q;
  assign bus.dataWrite = dw_q;
  assign bus.dataRead = dr_q;
  assign bus.sysClear = clr_q;
  assign bus.hostData = datBus_q;
endmodule

//--- logic/arl_pkg.sv
// package: shared constants and types for the addressed relay output latch
package arl_pkg;
  localparam int ARL_ADDR_W = 6;
  localparam int ARL_DATA_W = 8;
  localparam logic [7:0] ARL_LATCH_RST = 8'h00;
  // host-side axi register offsets
  localparam logic [7:0] ARL_OFS_CTRL = 8'h00;
  localparam logic [7:0] ARL_OFS_BOARD = 8'h04;
  localparam logic [7:0] ARL_OFS_WDATA = 8'h08;
  localparam logic [7:0] ARL_OFS_STAT = 8'h0c;
  localparam logic [7:0] ARL_OFS_RDATA = 8'h10;
  // control register bit positions
  localparam int ARL_CTRL_GO = 0;
  localparam int ARL_CTRL_RD = 1;
  localparam int ARL_CTRL_CLR = 2;
  localparam int ARL_CTRL_RMW = 3;
  // axi response codes
  localparam logic [1:0] ARL_RESP_OK = 2'h0;
  localparam logic [1:0] ARL_RESP_SLVERR = 2'h2;
  // host sequencer states
  typedef enum logic [4:0] {
    ARL_IDLE = 5'h01,
    ARL_PTR = 5'h02,
    ARL_READ = 5'h04,
    ARL_CAP = 5'h08,
    ARL_WRITE = 5'h10
  } arl_state_t;
endpackage

//--- logic/arl_bus_if.sv
// interface: multi-drop cable between host driver and relay board
`timescale 1ns/100ps
interface arl_bus_if;
  logic ptrWrite;
  logic dataWrite;
  logic dataRead;
  logic sysClear;
  logic [7:0] hostData;
  logic [7:0] boardData;
  logic boardDataOe;
  modport host (
    output ptrWrite,
    output dataWrite,
    output dataRead,
    output sysClear,
    output hostData,
    input boardData,
    input boardDataOe
  );
  modport board (
    input ptrWrite,
    input dataWrite,
    input dataRead,
    input sysClear,
    input hostData,
    output boardData,
    output boardDataOe
  );
endinterface

//--- logic/arl_relay_board.sv
// module: relay board end, switch-addressed 8-bit output latch
`timescale 1ns/100ps
module arl_relay_board import arl_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [ARL_ADDR_W-1:0] addrSwitchOn,
  arl_bus_if.board bus,
  output logic [ARL_DATA_W-1:0] relayDrive,
  output logic [ARL_DATA_W-1:0] ledDrive
);
  // ------------------------------------------------------------
  // switch and cable sampling
  // ------------------------------------------------------------
  logic [ARL_ADDR_W-1:0] swMeta_q, swSync_q;
  logic [3:0] ctlMeta_q, ctlSync_q;
  logic [7:0] datMeta_q, datSync_q;
  logic [ARL_ADDR_W-1:0] boardPtr_q;
  logic [7:0] latch_q;
  logic [7:0] rdData_q;
  logic rdOe_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      swMeta_q <= '0;
      swSync_q <= '0;
      ctlMeta_q <= '0;
      ctlSync_q <= '0;
      datMeta_q <= '0;
      datSync_q <= '0;
    end else if (clkEn) begin
      swMeta_q <= addrSwitchOn;
      swSync_q <= swMeta_q;
      ctlMeta_q <= {bus.sysClear, bus.dataRead, bus.dataWrite, bus.ptrWrite};
      ctlSync_q <= ctlMeta_q;
      datMeta_q <= bus.hostData;
      datSync_q <= datMeta_q;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // switch bit k on adds 2**k, off adds zero, so the bank is the address
  wire [ARL_ADDR_W-1:0] boardAddr = swSync_q;
  wire selected = (boardPtr_q == boardAddr);
  wire ptrWr = ctlSync_q[0];
  wire dataWr = ctlSync_q[1] && selected;
  wire dataRd = ctlSync_q[2] && selected;
  wire sysClr = ctlSync_q[3];

  // ------------------------------------------------------------
  // pointer and latch
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boardPtr_q <= '0;
      latch_q <= ARL_LATCH_RST;
    end else if (clkEn) begin
      if (ptrWr) begin
        boardPtr_q <= datSync_q[ARL_ADDR_W-1:0];
      end
      if (sysClr) begin
        latch_q <= ARL_LATCH_RST;
      end else if (dataWr) begin
        latch_q <= datSync_q;
      end
    end
  end

  // ------------------------------------------------------------
  // read back and outputs
  // ------------------------------------------------------------
  // reads never touch the latch; lines released when not selected
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= '0;
      rdOe_q <= 1'b0;
      relayDrive <= ARL_LATCH_RST;
      ledDrive <= ARL_LATCH_RST;
    end else if (clkEn) begin
      rdOe_q <= dataRd;
      rdData_q <= dataRd ? latch_q : 8'h00;
      relayDrive <= latch_q;
      ledDrive <= latch_q;
    end
  end

  assign bus.boardData = rdData_q;
  assign bus.boardDataOe = rdOe_q;
endmodule

//--- sim/arl_cable_checker.sv
// checker: cable timing between host driver and relay board
`timescale 1ns/100ps
module arl_cable_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ptrWrite,
  input wire logic dataWrite,
  input wire logic dataRead,
  input wire logic sysClear,
  input wire logic [7:0] hostData,
  input wire logic [7:0] boardData,
  input wire logic boardDataOe
);
  // ----
  // pointer and write strobes held for the hold count of 6, read strobe for at least 6
  // ----
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  ptr_strobe_len_a: assert property ($rose(ptrWrite) |->
    ptrWrite [*6] ##1 !ptrWrite) else $error("pointer strobe length");
  wr_strobe_len_a: assert property ($rose(dataWrite) |->
    dataWrite [*6] ##1 !dataWrite) else $error("write strobe length");
  rd_strobe_len_a: assert property ($rose(dataRead) |->
    dataRead [*6]) else $error("read strobe length");
  one_phase_a: assert property (ptrWrite |->
    !dataWrite && !dataRead) else $error("pointer overlaps data");
  wr_data_hold_a: assert property (dataWrite && $past(dataWrite) |->
    $stable(hostData)) else $error("write data moved");
  ptr_value_hold_a: assert property (ptrWrite && $past(ptrWrite) |->
    $stable(hostData[5:0])) else $error("pointer moved");
  idle_data_a: assert property (!boardDataOe |->
    boardData == 8'h00) else $error("data driven while idle");
  drive_cause_a: assert property (boardDataOe |->
    $past(dataRead, 2) || $past(dataRead, 3) || $past(dataRead, 4) ||
    $past(dataRead, 5)) else $error("board drove without a read");
endmodule

//--- sim/test_addressed_relay_output_latch.sv
// testbench: host driver and relay board joined over the cable
`timescale 1ns/100ps
module test_addressed_relay_output_latch import arl_pkg::*;;
  logic core_clk = 0;
  logic rstn = 0;
  logic [5:0] addrSw = 6'h14;
  logic boardEn = 1'b1;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] relays, leds;
  int failures = 0;
  int checked = 0;
  int waits;
  arl_bus_if cable ();
  arl_host_driver #(.HOLD_CYC(6)) i_arl_host_driver (.core_clk(core_clk),
    .rstn(rstn), .clkEn(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(cable));
  arl_relay_board i_arl_relay_board (.core_clk(core_clk), .rstn(rstn),
    .clkEn(boardEn), .addrSwitchOn(addrSw), .bus(cable),
    .relayDrive(relays), .ledDrive(leds));
  arl_cable_checker i_arl_cable_checker (.core_clk(core_clk),
    .rstn(rstn), .ptrWrite(cable.ptrWrite), .dataWrite(cable.dataWrite),
    .dataRead(cable.dataRead), .sysClear(cable.sysClear),
    .hostData(cable.hostData), .boardData(cable.boardData),
    .boardDataOe(cable.boardDataOe));
  initial forever #25 core_clk = ~core_clk;
  // ----
  // bus cycles and compare
  // ----
  task print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task step();
    @(posedge core_clk);
    waits++;
    if (waits > 400) begin
      failures++;
      $display("ERROR %0t wait timed out", $time);
      print_verdict();
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    waits = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      step();
      if (aw && awready === 1'b1) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready === 1'b1) begin
        w = 0;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) step();
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    waits = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    step();
    while (arready !== 1'b1) step();
    arvalid <= 0;
    while (rvalid !== 1'b1) step();
    d = rdata;
    r = rresp;
  endtask
  // pointer, data and command, then poll busy until clear
  task op(input logic [5:0] b, input logic [7:0] d, input logic [3:0] c);
    logic [31:0] s;
    logic [1:0] r;
    wr(ARL_OFS_BOARD, {26'h0, b});
    wr(ARL_OFS_WDATA, {24'h0, d});
    wr(ARL_OFS_CTRL, {28'h0, c});
    s = 1;
    for (int k = 0; k < 60 && s[0] !== 1'b0; k++) rd(ARL_OFS_STAT, s, r);
    chk(s[0], 1'b0);
  endtask
  // ----
  // scenarios
  // ----
  task t_walk();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      op(6'h14, 8'h01 << i, 4'h1);
      chk(relays, 8'h01 << i);
      chk(leds, 8'h01 << i);
      op(6'h14, 8'h00, 4'h3);
      rd(ARL_OFS_RDATA, d, r);
      chk(d[7:0], 8'h01 << i);
      chk(relays, 8'h01 << i);
    end
  endtask
  task t_rmw();
    op(6'h14, 8'h21, 4'h1);
    chk(relays, 8'h21);
    op(6'h14, 8'h04, 4'h9);
    chk(relays, 8'h25);
  endtask
  // switches move; stale pointer must no longer reach the latch
  task t_select();
    addrSw <= 6'h18;
    op(6'h14, 8'hff, 4'h1);
    chk(relays, 8'h25);
    op(6'h18, 8'h3c, 4'h1);
    chk(relays, 8'h3c);
    addrSw <= 6'h3f;
    op(6'h3f, 8'h81, 4'h1);
    chk(leds, 8'h81);
  endtask
  // a frozen board must miss a whole write while the host runs on
  task t_freeze();
    boardEn <= 1'b0;
    op(6'h3f, 8'h55, 4'h1);
    chk(relays, 8'h81);
    boardEn <= 1'b1;
    waits = 0;
    repeat (4) step();
    chk(relays, 8'h81);
  endtask
  task t_clear();
    logic [31:0] d;
    logic [1:0] r;
    op(6'h3f, 8'h00, 4'h5);
    waits = 0;
    repeat (3) step();
    chk(relays, 8'h00);
    chk(leds, 8'h00);
    rd(8'h14, d, r);
    chk(r, ARL_RESP_SLVERR);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    chk(relays, 8'h00);
    t_walk();
    t_rmw();
    t_select();
    t_freeze();
    t_clear();
    print_verdict();
  end
endmodule
